// ### design/cyclic_io_image_framer.sv
// Summary of operation
// - Input image length is 1 to 265 bytes; exactly that many bytes go out.
// - Input byte 3 carries the current result fragment index.
// - Input byte 4 holds remaining fragments, byte 5 the fragment size.
// - Result length is 16 bits: low in input byte 8, high in byte 9.
// - Result payload starts at input byte 10; controller sets how many.
// - Output image arrives cyclically; lengths 1 to 263 bytes accepted.
// - Output byte 1: switch 1 on, counter 1 reset, switch 2 on, counter 2 reset.
// - Switch activation bits act only when set for external event control.
// - Output bytes 2, 3, 4 give entry fragment index, remaining count, size.
// - Entry length is 16 bits: low in output byte 6, high in byte 7.
// - Entry payload starts at output byte 8; controller sizes image 8 plus length.
// - One-byte output image: only the control byte, all else absent.
// - Two-byte output image: byte 1 switch and counter bits also apply.
// - Input result flag byte holds status, user data, buffer, overflow, toggle, wait bits.
// - Input image goes out cyclically with status and results.
`timescale 1ns/1ps
`default_nettype none
module cyclic_io_image_framer
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [framer_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [framer_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic irq,
  input wire logic cycleStart,
  output logic imgValid,
  input wire logic imgReady,
  output logic [7:0] imgData,
  output logic imgLast,
  input wire logic outValid,
  output logic outReady,
  input wire logic [7:0] outData,
  input wire logic outLast,
  input wire logic sw1IoPin,
  input wire logic sw1CmpPin,
  input wire logic sw2IoPin,
  input wire logic sw2CmpPin,
  output logic switchOut1,
  output logic switchOut2,
  output logic ctrReset1,
  output logic ctrReset2,
  output logic activation,
  output logic dataAck,
  output logic dataReset,
  output logic errAck,
  output logic standby
);
  import framer_pkg::*;

  typedef struct packed {
    logic [8:0] inLen;
    logic [8:0] outLen;
    logic [7:0] devStatus;
    logic [5:0] resFlags;
    logic [7:0] fragIdx;
    logic [7:0] fragRem;
    logic [7:0] fragSize;
    logic [7:0] numRes;
    logic [15:0] resLen;
    logic [PAYLOAD_BYTES-1:0][7:0] resData;
    logic [1:0] swCfg;
    logic accTgl;
    logic rejTgl;
    logic [2:0] errCode;
    logic [7:0][7:0] hdrShadow;
    logic [7:0][7:0] hdrLive;
    logic [PAYLOAD_BYTES-1:0][7:0] entry;
    logic [7:0] entrySel;
    logic [3:0] pinMeta;
    logic [3:0] pinSync;
    logic [1:0] cmpPrev;
    logic [1:0] cmpTgl;
    logic [1:0] swOut;
    logic [1:0] ctrPrev;
    logic [1:0] ctrPulse;
    logic [IRQ_W-1:0] irqStat;
    logic [IRQ_W-1:0] irqMask;
    logic awGot;
    logic wGot;
    logic [ADDR_W-1:0] awAddr;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } m_t;

  m_t s_ff;
  m_t nxt_s;
  logic [8:0] byteSel;
  logic [7:0] selByte;
  logic bldBusy;
  logic bldDone;
  logic pStb;
  logic [8:0] pIdx;
  logic [7:0] pData;
  logic pEnd;

  // ==========================================================
  // Helpers
  function automatic logic [8:0] clampLen(input logic [8:0] v, input logic [8:0] mx);
    if (v < IN_LEN_MIN)
      return IN_LEN_MIN;
    else if (v > mx)
      return mx;
    else
      return v;
  endfunction

  function automatic logic [31:0] strbMask(input logic [3:0] st);
    return {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
  endfunction

  function automatic logic [7:0] switchByte(input m_t m);
    return {1'b0, m.cmpTgl[1], m.pinSync[3:2], 1'b0, m.cmpTgl[0], m.pinSync[1:0]};
  endfunction

  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a <= REG_IRQ_MASK);
  endfunction

  function automatic logic [31:0] readReg(input m_t m, input logic [ADDR_W-1:0] a);
    case (a)
      REG_IN_LEN: return {23'h0, m.inLen};
      REG_OUT_LEN: return {23'h0, m.outLen};
      REG_DEV_STATUS: return {24'h0, m.devStatus};
      REG_RES_FLAGS: return {26'h0, m.resFlags};
      REG_RES_FRAG: return {m.numRes, m.fragSize, m.fragRem, m.fragIdx};
      REG_RES_LEN: return {16'h0, m.resLen};
      REG_CMD: return {25'h0, m.errCode, 1'b0, m.rejTgl, m.accTgl, m.resFlags[RES_NEW_TGL]};
      REG_SW_CFG: return {16'h0, switchByte(m), 6'h0, m.swCfg};
      REG_OUT_HDR0: return {m.hdrLive[3], m.hdrLive[2], m.hdrLive[1], m.hdrLive[0]};
      REG_OUT_HDR1: return {m.hdrLive[7], m.hdrLive[6], m.hdrLive[5], m.hdrLive[4]};
      REG_ENTRY: return {16'h0, m.entry[m.entrySel], m.entrySel};
      REG_IRQ_STAT: return {27'h0, m.irqStat};
      REG_IRQ_MASK: return {27'h0, m.irqMask};
      default: return 32'h0000_0000;
    endcase
  endfunction

  // ==========================================================
  // Input image byte source
  always_comb
  begin
    logic [8:0] off;
    off = byteSel - IB_DATA;
    case (byteSel)
      IB_DEV_STATUS: selByte = s_ff.devStatus;
      IB_SWITCH: selByte = switchByte(s_ff);
      IB_ENTRY_ACK: selByte = {1'b0, s_ff.errCode, 2'b00, s_ff.rejTgl, s_ff.accTgl};
      IB_FRAG_IDX: selByte = s_ff.fragIdx;
      IB_FRAG_REM: selByte = s_ff.fragRem;
      IB_FRAG_SIZE: selByte = s_ff.fragSize;
      IB_NUM_RES: selByte = s_ff.numRes;
      IB_FLAGS: selByte = {2'b00, s_ff.resFlags};
      IB_LEN_LO: selByte = s_ff.resLen[7:0];
      IB_LEN_HI: selByte = s_ff.resLen[15:8];
      default:
      begin
        // Payload from byte 10, as many as the configured length allows
        if (byteSel >= IB_DATA && off < 9'(PAYLOAD_BYTES))
          selByte = s_ff.resData[off[7:0]];
        else
          selByte = 8'h00;
      end
    endcase
  end

  // ==========================================================
  // Next state
  always_comb
  begin
    logic [31:0] wMask;
    logic [31:0] wv;
    logic [31:0] wm;
    logic [8:0] eOff;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] clr;
    logic doWrite;
    nxt_s = s_ff;
    wMask = strbMask(s_ff.wStrb);
    wm = s_ff.wData & wMask;
    wv = (readReg(s_ff, s_ff.awAddr) & ~wMask) | wm;
    eOff = pIdx - OB_DATA;
    ev = '0;
    clr = '0;
    doWrite = s_ff.awGot && s_ff.wGot && !s_ff.bvalid;

    // Pin synchronisers and comparison toggles
    nxt_s.pinMeta = {sw2CmpPin, sw2IoPin, sw1CmpPin, sw1IoPin};
    nxt_s.pinSync = s_ff.pinMeta;
    nxt_s.cmpPrev = {s_ff.pinSync[3], s_ff.pinSync[1]};
    if (s_ff.cmpPrev != {s_ff.pinSync[3], s_ff.pinSync[1]})
    begin
      nxt_s.cmpTgl = s_ff.cmpTgl ^ (s_ff.cmpPrev ^ {s_ff.pinSync[3], s_ff.pinSync[1]});
      ev[EV_CMP_CHG] = 1'b1;
    end

    // Output image capture
    if (pStb)
    begin
      if (pIdx == OB_CTRL)
        nxt_s.hdrShadow = '0;
      if (pIdx < s_ff.outLen)
      begin
        if (pIdx < OB_DATA)
          nxt_s.hdrShadow[pIdx[2:0]] = pData;
        else if (eOff < 9'(PAYLOAD_BYTES))
          nxt_s.entry[eOff[7:0]] = pData;
      end
    end
    if (pEnd)
    begin
      // Header bytes beyond the configured length stay cleared, so those functions are absent
      nxt_s.hdrLive = nxt_s.hdrShadow;
      ev[EV_OUT_IMAGE] = 1'b1;
      if (nxt_s.hdrShadow[OB_NEW_ENTRY[2:0]][0] != s_ff.hdrLive[OB_NEW_ENTRY[2:0]][0])
        ev[EV_NEW_ENTRY] = 1'b1;
    end

    // Output byte 1 decode
    nxt_s.swOut[0] = s_ff.hdrLive[OB_SWITCH[2:0]][OS_SW1_ON] && s_ff.swCfg[0];
    nxt_s.swOut[1] = s_ff.hdrLive[OB_SWITCH[2:0]][OS_SW2_ON] && s_ff.swCfg[1];
    nxt_s.ctrPrev = {s_ff.hdrLive[OB_SWITCH[2:0]][OS_CTR2_RST],
                     s_ff.hdrLive[OB_SWITCH[2:0]][OS_CTR1_RST]};
    nxt_s.ctrPulse = nxt_s.ctrPrev & ~s_ff.ctrPrev;
    if (nxt_s.ctrPulse != 2'b00)
      ev[EV_CTR_RST] = 1'b1;

    if (bldDone)
      ev[EV_IN_SENT] = 1'b1;

    // ==========================================================
    // AXI4-Lite write channel
    if (s_axi_awvalid && !s_ff.awGot && !s_ff.bvalid)
    begin
      nxt_s.awGot = 1'b1;
      nxt_s.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s_ff.wGot && !s_ff.bvalid)
    begin
      nxt_s.wGot = 1'b1;
      nxt_s.wData = s_axi_wdata;
      nxt_s.wStrb = s_axi_wstrb;
    end
    if (doWrite)
    begin
      nxt_s.awGot = 1'b0;
      nxt_s.wGot = 1'b0;
      nxt_s.bvalid = 1'b1;
      nxt_s.bresp = mapped(s_ff.awAddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_ff.awAddr)
        REG_IN_LEN: nxt_s.inLen = clampLen(wv[8:0], IN_LEN_MAX);
        REG_OUT_LEN: nxt_s.outLen = clampLen(wv[8:0], OUT_LEN_MAX);
        REG_DEV_STATUS: nxt_s.devStatus = wv[7:0];
        REG_RES_FLAGS:
        begin
          nxt_s.resFlags = wv[5:0];
          nxt_s.resFlags[RES_NEW_TGL] = s_ff.resFlags[RES_NEW_TGL];
        end
        REG_RES_FRAG:
        begin
          nxt_s.fragIdx = wv[7:0];
          nxt_s.fragRem = wv[15:8];
          nxt_s.fragSize = wv[23:16];
          nxt_s.numRes = wv[31:24];
        end
        REG_RES_LEN: nxt_s.resLen = wv[15:0];
        REG_RES_DATA:
        begin
          if (s_ff.wStrb[0] && s_ff.wStrb[1] && s_ff.wData[15:8] < 8'(PAYLOAD_BYTES))
            nxt_s.resData[s_ff.wData[15:8]] = s_ff.wData[7:0];
        end
        REG_CMD:
        begin
          if (wm[CMD_NEW_RESULT])
            nxt_s.resFlags[RES_NEW_TGL] = ~s_ff.resFlags[RES_NEW_TGL];
          if (wm[CMD_ACCEPT])
            nxt_s.accTgl = ~s_ff.accTgl;
          if (wm[CMD_REJECT])
          begin
            nxt_s.rejTgl = ~s_ff.rejTgl;
            nxt_s.errCode = wm[CMD_ERR_LSB+2:CMD_ERR_LSB];
          end
        end
        REG_SW_CFG: nxt_s.swCfg = wv[1:0];
        REG_ENTRY: nxt_s.entrySel = wv[7:0];
        REG_IRQ_STAT: clr = wm[IRQ_W-1:0];
        REG_IRQ_MASK: nxt_s.irqMask = wv[IRQ_W-1:0];
        default: nxt_s.bresp = RESP_SLVERR;
      endcase
    end
    if (s_ff.bvalid && s_axi_bready)
      nxt_s.bvalid = 1'b0;

    // Sticky events; a new event beats a clear in the same cycle
    nxt_s.irqStat = (s_ff.irqStat & ~clr) | ev;

    // ==========================================================
    // AXI4-Lite read channel
    if (s_axi_arvalid && !s_ff.rvalid)
    begin
      nxt_s.rvalid = 1'b1;
      nxt_s.rdata = readReg(s_ff, s_axi_araddr);
      nxt_s.rresp = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_ff.rvalid && s_axi_rready)
    begin
      nxt_s.rvalid = 1'b0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_ff <= '0;
      s_ff.inLen <= IN_LEN_MAX;
      s_ff.outLen <= OUT_LEN_MAX;
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // ==========================================================
  // Image streams
  image_builder #(.LW(LEN_W)) u_builder
  (
    .mclk(mclk),
    .rst(rst),
    .start(cycleStart && !bldBusy),
    .len(s_ff.inLen),
    .byteSel(byteSel),
    .byteIn(selByte),
    .imgValid(imgValid),
    .imgReady(imgReady),
    .imgData(imgData),
    .imgLast(imgLast),
    .busy(bldBusy),
    .done(bldDone)
  );

  image_parser #(.LW(LEN_W)) u_parser
  (
    .mclk(mclk),
    .rst(rst),
    .outValid(outValid),
    .outReady(outReady),
    .outData(outData),
    .outLast(outLast),
    .byteStb(pStb),
    .byteIdx(pIdx),
    .byteData(pData),
    .frameEnd(pEnd)
  );

  // ==========================================================
  // Outputs
  assign s_axi_awready = !s_ff.awGot && !s_ff.bvalid;
  assign s_axi_wready = !s_ff.wGot && !s_ff.bvalid;
  assign s_axi_bvalid = s_ff.bvalid;
  assign s_axi_bresp = s_ff.bresp;
  assign s_axi_arready = !s_ff.rvalid;
  assign s_axi_rvalid = s_ff.rvalid;
  assign s_axi_rdata = s_ff.rdata;
  assign s_axi_rresp = s_ff.rresp;
  assign irq = |(s_ff.irqStat & s_ff.irqMask);
  assign switchOut1 = s_ff.swOut[0];
  assign switchOut2 = s_ff.swOut[1];
  assign ctrReset1 = s_ff.ctrPulse[0];
  assign ctrReset2 = s_ff.ctrPulse[1];
  assign activation = s_ff.hdrLive[OB_CTRL[2:0]][OC_ACTIVATE];
  assign dataAck = s_ff.hdrLive[OB_CTRL[2:0]][OC_DATA_ACK];
  assign dataReset = s_ff.hdrLive[OB_CTRL[2:0]][OC_DATA_RESET];
  assign errAck = s_ff.hdrLive[OB_CTRL[2:0]][OC_ERR_ACK];
  assign standby = s_ff.hdrLive[OB_CTRL[2:0]][OC_STANDBY];
endmodule
`default_nettype wire

// ### design/image_builder.sv
`timescale 1ns/1ps
`default_nettype none
module image_builder
#(
  parameter int unsigned LW = 9
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic [LW-1:0] len,
  output logic [LW-1:0] byteSel,
  input wire logic [7:0] byteIn,
  output logic imgValid,
  input wire logic imgReady,
  output logic [7:0] imgData,
  output logic imgLast,
  output logic busy,
  output logic done
);
  typedef enum logic [1:0] {IDLE = 2'b01, RUN = 2'b10} bst_t;
  typedef struct packed {
    bst_t st;
    logic [LW-1:0] idx;
    logic valid;
    logic [7:0] data;
    logic last;
    logic done;
  } b_t;

  b_t s_ff;
  b_t nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    case (s_ff.st)
      IDLE:
      begin
        if (start)
        begin
          nxt_s.idx = '0;
          nxt_s.st = RUN;
        end
      end
      RUN:
      begin
        if (!s_ff.valid || imgReady)
        begin
          // Exactly len bytes leave per image
          if (s_ff.idx < len)
          begin
            nxt_s.valid = 1'b1;
            nxt_s.data = byteIn;
            nxt_s.last = (s_ff.idx == len - LW'(1));
            nxt_s.idx = s_ff.idx + LW'(1);
          end
          else
          begin
            nxt_s.valid = 1'b0;
            nxt_s.last = 1'b0;
            nxt_s.done = 1'b1;
            nxt_s.st = IDLE;
          end
        end
      end
      default: nxt_s.st = IDLE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_ff <= '{st: IDLE, idx: '0, valid: 1'b0, data: 8'h00, last: 1'b0, done: 1'b0};
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  assign byteSel = s_ff.idx;
  assign imgValid = s_ff.valid;
  assign imgData = s_ff.data;
  assign imgLast = s_ff.last;
  assign busy = (s_ff.st == RUN);
  assign done = s_ff.done;
endmodule
`default_nettype wire

// ### design/image_parser.sv
`timescale 1ns/1ps
`default_nettype none
module image_parser
#(
  parameter int unsigned LW = 9
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic outValid,
  output logic outReady,
  input wire logic [7:0] outData,
  input wire logic outLast,
  output logic byteStb,
  output logic [LW-1:0] byteIdx,
  output logic [7:0] byteData,
  output logic frameEnd
);
  typedef struct packed {
    logic [LW-1:0] cnt;
    logic stb;
    logic [LW-1:0] idx;
    logic [7:0] data;
    logic fend;
  } p_t;

  p_t s_ff;
  p_t nxt_s;

  always_comb
  begin
    nxt_s = s_ff;
    nxt_s.stb = 1'b0;
    nxt_s.fend = 1'b0;
    if (outValid)
    begin
      nxt_s.stb = 1'b1;
      nxt_s.idx = s_ff.cnt;
      nxt_s.data = outData;
      nxt_s.fend = outLast;
      // Counter saturates so overlong images cannot wrap onto the header
      if (outLast)
        nxt_s.cnt = '0;
      else if (s_ff.cnt != '1)
        nxt_s.cnt = s_ff.cnt + LW'(1);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      s_ff <= '{cnt: '0, stb: 1'b0, idx: '0, data: 8'h00, fend: 1'b0};
    end
    else
    begin
      s_ff <= nxt_s;
    end
  end

  // Image arrives cyclically and is never stalled
  assign outReady = 1'b1;
  assign byteStb = s_ff.stb;
  assign byteIdx = s_ff.idx;
  assign byteData = s_ff.data;
  assign frameEnd = s_ff.fend;
endmodule
`default_nettype wire

// ### dv/ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module ctrl_model
(
  input wire logic mclk,
  input wire logic slow,
  input wire logic imgValid,
  output logic imgReady,
  input wire logic [7:0] imgData,
  input wire logic imgLast,
  output logic outValid,
  output logic [7:0] outData,
  output logic outLast
);
  logic [7:0] rx[$];
  logic [7:0] tx[$];
  int nFrames = 0;
  // ==========================================
  // Controller end of both images
  initial
  begin
    imgReady = 1'h0;
    outValid = 1'h0;
    outData = 8'h00;
    outLast = 1'h0;
  end
  always @(posedge mclk)
  begin
    if (imgValid && imgReady)
      rx.push_back(imgData);
    if (imgValid && imgReady && imgLast)
      nFrames <= nFrames + 1;
    imgReady <= slow ? 1'($urandom_range(1, 0)) : 1'h1;
    outValid <= tx.size() > 0;
    outLast <= tx.size() == 1;
    // Idle data keeps moving so stale bytes never look valid
    outData <= tx.size() > 0 ? tx.pop_front() : ~outData;
  end
endmodule
`default_nettype wire

// ### dv/framer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module framer_monitor
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic imgValid,
  input wire logic imgReady,
  input wire logic [7:0] imgData,
  input wire logic imgLast,
  input wire logic outReady,
  input wire logic ctrReset1,
  input wire logic ctrReset2,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========================================
  // Image stream, handshakes and counter reset pulses
  sequence s_stall;
    imgValid && !imgReady;
  endsequence
  sequence s_held;
    imgValid && $stable(imgData) && $stable(imgLast);
  endsequence
  a_byte_held: assert property (s_stall |=> s_held)
    else $error("image byte changed while stalled");
  a_last_valid: assert property (imgLast |-> imgValid)
    else $error("last flag without valid");
  a_last_gap: assert property (imgValid && imgReady && imgLast |=> !imgValid [*2])
    else $error("image bytes beyond the last");
  a_out_open: assert property (outReady)
    else $error("output image stalled");
  a_ctr1_pulse: assert property (ctrReset1 |=> !ctrReset1)
    else $error("counter 1 reset longer than a cycle");
  a_ctr2_pulse: assert property (ctrReset2 |=> !ctrReset2)
    else $error("counter 2 reset longer than a cycle");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
endmodule
bind cyclic_io_image_framer framer_monitor u_mon (.mclk, .rst, .imgValid, .imgReady, .imgData,
  .imgLast, .outReady, .ctrReset1, .ctrReset2, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid,
  .s_axi_rready);
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import framer_pkg::*;
  logic mclk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, slow;
  logic cycleStart, imgValid, imgReady, imgLast, outValid, outReady, outLast, switchOut1;
  logic switchOut2, ctrReset1, ctrReset2, activation, dataAck, dataReset, errAck, standby;
  logic sw1IoPin, sw1CmpPin, sw2IoPin, sw2CmpPin, saw1 = 0, saw2 = 0;
  logic [7:0] s_axi_awaddr, s_axi_araddr, imgData, outData, dev, fl, s, ob[12], dat[8];
  logic [31:0] s_axi_wdata, s_axi_rdata, frag, d;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int miscompares = 0, n_compared = 0, n, lim;
  cyclic_io_image_framer u_dut (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .irq, .cycleStart, .imgValid, .imgReady, .imgData, .imgLast,
    .outValid, .outReady, .outData, .outLast, .sw1IoPin, .sw1CmpPin, .sw2IoPin, .sw2CmpPin,
    .switchOut1, .switchOut2, .ctrReset1, .ctrReset2, .activation, .dataAck, .dataReset,
    .errAck, .standby);
  ctrl_model u_ctrl (.mclk, .slow, .imgValid, .imgReady, .imgData, .imgLast, .outValid,
    .outData, .outLast);
  initial
  begin
    mclk = 1'h0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) saw1 <= saw1 | ctrReset1;
  always @(posedge mclk) saw2 <= saw2 | ctrReset2;
  // ==========================================
  // Checking and bus tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dv);
    logic ta, tw, got;
    s_axi_awaddr <= a;
    s_axi_wdata <= dv;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    do
    begin
      @(negedge mclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      {got, r} = {s_axi_bvalid, s_axi_bresp};
      @(posedge mclk);
      if (ta)
        s_axi_awvalid <= 1'h0;
      if (tw)
        s_axi_wvalid <= 1'h0;
    end while (!got);
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic tk, got;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    do
    begin
      @(negedge mclk);
      got = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      tk = s_axi_arvalid & s_axi_arready;
      @(posedge mclk);
      if (tk)
        s_axi_arvalid <= 1'h0;
    end while (!got);
    chk(nm, d, exp);
  endtask
  task automatic send_in();
    int f;
    f = u_ctrl.nFrames;
    u_ctrl.rx.delete();
    cycleStart <= 1'h1;
    @(posedge mclk);
    cycleStart <= 1'h0;
    while (u_ctrl.nFrames == f)
      @(posedge mclk);
    repeat (3) @(posedge mclk);
  endtask
  function automatic logic [7:0] ib(int k);
    case (k)
      0: return dev;
      2: return 8'h33;
      3, 4, 5, 6: return frag[8*(k-3) +: 8];
      7: return (fl & 8'h2F) | 8'h10;
      8: return n[7:0];
      9: return 8'h00;
      default: return dat[k-10];
    endcase
  endfunction
  function automatic logic [7:0] h(int k);
    return k < lim ? ob[k] : 8'h00;
  endfunction
  initial
  begin
    #200000;
    miscompares++;
    test_done();
  end
  // ==========================================
  // Main sequence
  initial
  begin
    {rst, s_axi_bready, s_axi_rready} = 3'h7;
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, cycleStart, slow} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    void'($urandom(32'hCDB1A647));
    {sw1IoPin, sw1CmpPin, sw2IoPin, sw2CmpPin} = 4'($urandom);
    repeat (8) @(posedge mclk);
    rst <= 1'h0;
    @(posedge mclk);
    rchk("in length", REG_IN_LEN, 32'h109);
    rchk("out length", REG_OUT_LEN, 32'h107);
    rchk("unmapped", 8'h3C, 32'h0);
    chk("unmapped resp", r, RESP_SLVERR);
    n = $urandom_range(8, 1);
    dev = $urandom;
    frag = $urandom;
    fl = $urandom & 8'h3F;
    wr(REG_IN_LEN, 10 + n);
    wr(REG_DEV_STATUS, dev);
    wr(REG_RES_FLAGS, fl);
    wr(REG_RES_FRAG, frag);
    wr(REG_RES_LEN, n);
    for (int i = 0; i < n; i++)
    begin
      dat[i] = $urandom;
      wr(REG_RES_DATA, {16'h0, 8'(i), dat[i]});
    end
    wr(REG_CMD, 32'h37);
    wr(REG_IRQ_MASK, 32'h4);
    chk("write resp", r, RESP_OKAY);
    slow <= 1'h1;
    send_in();
    chk("frame size", u_ctrl.rx.size(), 10 + n);
    for (int k = 0; k < 10 + n; k++)
      if (k != 1)
        chk("input byte", u_ctrl.rx[k], ib(k));
    chk("pin states", u_ctrl.rx[1] & 8'h33, {2'h0, sw2CmpPin, sw2IoPin, 2'h0, sw1CmpPin, sw1IoPin});
    chk("irq sent", irq, 1'h1);
    wr(REG_IRQ_STAT, 32'h1F);
    chk("irq cleared", irq, 1'h0);
    wr(REG_IN_LEN, 32'h0);
    rchk("in length min", REG_IN_LEN, 32'h1);
    slow <= 1'h0;
    send_in();
    chk("short frame", u_ctrl.rx.size(), 1);
    wr(REG_IRQ_STAT, 32'h4);
    wr(REG_SW_CFG, 32'h3);
    for (int t = 0; t < 4; t++)
    begin
      lim = t < 2 ? t + 1 : 12;
      wr(REG_OUT_LEN, lim);
      if (t == 3)
        wr(REG_SW_CFG, 32'h0);
      foreach (ob[i])
        ob[i] = $urandom;
      ob[1] = t == 1 ? 8'h0F : t == 3 ? 8'h05 : ob[1];
      ob[6] = 8'h04;
      ob[7] = 8'h00;
      for (int i = 0; i < 12; i++)
        u_ctrl.tx.push_back(ob[i]);
      while (u_ctrl.tx.size() > 0)
        @(posedge mclk);
      repeat (4) @(posedge mclk);
      s = h(1);
      rchk("header low", REG_OUT_HDR0, {h(3), h(2), h(1), h(0)});
      rchk("header high", REG_OUT_HDR1, {h(7), h(6), h(5), h(4)});
      chk("control", {standby, errAck, dataReset, dataAck, activation}, ob[0][4:0]);
      chk("switches", {switchOut2, switchOut1}, {s[2], s[0]} & {2{t < 3}});
      if (t == 2)
        wr(REG_ENTRY, 32'h1);
      if (t == 2)
        rchk("entry byte", REG_ENTRY, {16'h0, ob[9], 8'h01});
    end
    chk("counter resets", {saw2, saw1}, 2'h3);
    chk("irq masked", irq, 1'h0);
    test_done();
  end
endmodule
`default_nettype wire

// ### include/framer_pkg.sv
package framer_pkg;

  // ==========================================================
  // Image geometry
  localparam int unsigned LEN_W = 9;
  localparam logic [8:0] IN_LEN_MIN = 9'h001;
  localparam logic [8:0] IN_LEN_MAX = 9'h109;
  localparam logic [8:0] OUT_LEN_MAX = 9'h107;
  localparam int unsigned PAYLOAD_BYTES = 255;

  // Input image byte positions
  localparam logic [8:0] IB_DEV_STATUS = 9'h000;
  localparam logic [8:0] IB_SWITCH = 9'h001;
  localparam logic [8:0] IB_ENTRY_ACK = 9'h002;
  localparam logic [8:0] IB_FRAG_IDX = 9'h003;
  localparam logic [8:0] IB_FRAG_REM = 9'h004;
  localparam logic [8:0] IB_FRAG_SIZE = 9'h005;
  localparam logic [8:0] IB_NUM_RES = 9'h006;
  localparam logic [8:0] IB_FLAGS = 9'h007;
  localparam logic [8:0] IB_LEN_LO = 9'h008;
  localparam logic [8:0] IB_LEN_HI = 9'h009;
  localparam logic [8:0] IB_DATA = 9'h00A;

  // Output image byte positions
  localparam logic [8:0] OB_CTRL = 9'h000;
  localparam logic [8:0] OB_SWITCH = 9'h001;
  localparam logic [8:0] OB_FRAG_IDX = 9'h002;
  localparam logic [8:0] OB_FRAG_REM = 9'h003;
  localparam logic [8:0] OB_FRAG_SIZE = 9'h004;
  localparam logic [8:0] OB_NEW_ENTRY = 9'h005;
  localparam logic [8:0] OB_LEN_LO = 9'h006;
  localparam logic [8:0] OB_LEN_HI = 9'h007;
  localparam logic [8:0] OB_DATA = 9'h008;

  // Output control byte bits
  localparam int unsigned OC_ACTIVATE = 0;
  localparam int unsigned OC_DATA_ACK = 1;
  localparam int unsigned OC_DATA_RESET = 2;
  localparam int unsigned OC_ERR_ACK = 3;
  localparam int unsigned OC_STANDBY = 4;
  // Output switching byte bits
  localparam int unsigned OS_SW1_ON = 0;
  localparam int unsigned OS_CTR1_RST = 1;
  localparam int unsigned OS_SW2_ON = 2;
  localparam int unsigned OS_CTR2_RST = 3;

  // ==========================================================
  // Register map (byte addresses)
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] REG_IN_LEN = 8'h00;
  localparam logic [7:0] REG_OUT_LEN = 8'h04;
  localparam logic [7:0] REG_DEV_STATUS = 8'h08;
  localparam logic [7:0] REG_RES_FLAGS = 8'h0C;
  localparam logic [7:0] REG_RES_FRAG = 8'h10;
  localparam logic [7:0] REG_RES_LEN = 8'h14;
  localparam logic [7:0] REG_RES_DATA = 8'h18;
  localparam logic [7:0] REG_CMD = 8'h1C;
  localparam logic [7:0] REG_SW_CFG = 8'h20;
  localparam logic [7:0] REG_OUT_HDR0 = 8'h24;
  localparam logic [7:0] REG_OUT_HDR1 = 8'h28;
  localparam logic [7:0] REG_ENTRY = 8'h2C;
  localparam logic [7:0] REG_IRQ_STAT = 8'h30;
  localparam logic [7:0] REG_IRQ_MASK = 8'h34;

  // Command register bits
  localparam int unsigned CMD_NEW_RESULT = 0;
  localparam int unsigned CMD_ACCEPT = 1;
  localparam int unsigned CMD_REJECT = 2;
  localparam int unsigned CMD_ERR_LSB = 4;
  localparam int unsigned RES_NEW_TGL = 4;

  // Interrupt status bits
  localparam int unsigned IRQ_W = 5;
  localparam int unsigned EV_OUT_IMAGE = 0;
  localparam int unsigned EV_NEW_ENTRY = 1;
  localparam int unsigned EV_IN_SENT = 2;
  localparam int unsigned EV_CTR_RST = 3;
  localparam int unsigned EV_CMP_CHG = 4;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage
